/* File: rtl/psb_agent.sv */
`timescale 1ns/10ps
module psb_agent
	import psb_pkg::*;
#(
	parameter int TMO_CYCLES = DEVSEL_TIMEOUT
) (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// bus inputs from pins, active low except ad, cbe, par and idsel
	input wire logic [31:0] ad_i,
	input wire logic [3:0] cbe_i,
	input wire logic par_i,
	input wire logic frame_n_i,
	input wire logic irdy_n_i,
	input wire logic trdy_n_i,
	input wire logic stop_n_i,
	input wire logic devsel_n_i,
	input wire logic idsel_i,
	input wire logic gnt_n_i,
	// bus outputs with enables
	output logic frame_n_o,
	output logic frame_oe,
	output logic irdy_n_o,
	output logic irdy_oe,
	output logic trdy_n_o,
	output logic trdy_oe,
	output logic stop_n_o,
	output logic stop_oe,
	output logic devsel_n_o,
	output logic devsel_oe,
	output logic perr_n_o,
	output logic perr_oe,
	output logic serr_n_o,
	output logic serr_oe,
	output logic req_n_o,
	output logic req_oe,
	output logic inta_n_o,
	output logic inta_oe,
	output logic transmit_driver_enable,
	// user side
	input wire logic mst_start,
	input wire logic tgt_stop_req,
	input wire logic fatal_err,
	input wire logic [NUM_IRQ-1:0] irq_mask,
	input wire logic [NUM_IRQ-1:0] irq_ack,
	input wire logic [NUM_IRQ-3:0] irq_ext,
	output logic mst_busy,
	output logic mst_abort,
	output logic cfg_access,
	output logic cfg_write,
	output logic [NUM_IRQ-1:0] irq_status
);
	typedef struct packed {
		logic [31:0] ad1;
		logic [31:0] ad2;
		logic [3:0] cbe1;
		logic [3:0] cbe2;
		logic par1;
		logic par2;
		logic frame1;
		logic frame2;
		logic irdy1;
		logic irdy2;
		logic trdy1;
		logic trdy2;
		logic stop1;
		logic stop2;
		logic devsel1;
		logic devsel2;
		logic idsel1;
		logic idsel2;
		logic gnt1;
		logic gnt2;
		logic frame_prev;
		logic par_chk;
		logic par_chk_d;
		psb_mst_t ms;
		psb_tgt_t ts;
		logic [2:0] tmo;
		logic req;
		logic mframe;
		logic mirdy;
		logic mact;
		logic devsel;
		logic trdy;
		logic stop;
		logic topen;
		logic perr;
		logic serr;
		logic abort;
		logic cfg;
		logic cfgw;
		logic [NUM_IRQ-1:0] irq;
		logic inta;
	} psb_state_t;

	psb_state_t st_ff;
	psb_state_t nxt_st;
	logic [NUM_IRQ-1:0] irq_set;
	logic addr_phase;
	logic tgt_done;

	always_comb begin
		nxt_st = st_ff;
		// two-flop synchronisers; only stage 2 is read
		nxt_st.ad1 = ad_i;
		nxt_st.ad2 = st_ff.ad1;
		nxt_st.cbe1 = cbe_i;
		nxt_st.cbe2 = st_ff.cbe1;
		nxt_st.par1 = par_i;
		nxt_st.par2 = st_ff.par1;
		nxt_st.frame1 = frame_n_i;
		nxt_st.frame2 = st_ff.frame1;
		nxt_st.irdy1 = irdy_n_i;
		nxt_st.irdy2 = st_ff.irdy1;
		nxt_st.trdy1 = trdy_n_i;
		nxt_st.trdy2 = st_ff.trdy1;
		nxt_st.stop1 = stop_n_i;
		nxt_st.stop2 = st_ff.stop1;
		nxt_st.devsel1 = devsel_n_i;
		nxt_st.devsel2 = st_ff.devsel1;
		nxt_st.idsel1 = idsel_i;
		nxt_st.idsel2 = st_ff.idsel1;
		nxt_st.gnt1 = gnt_n_i;
		nxt_st.gnt2 = st_ff.gnt1;
		nxt_st.frame_prev = st_ff.frame2;
		addr_phase = st_ff.frame_prev && !st_ff.frame2 && !st_ff.mact;
		// even parity: held one clock, compared with parity arriving a clock later
		nxt_st.par_chk = ^{st_ff.ad2, st_ff.cbe2};
		nxt_st.par_chk_d = st_ff.par_chk;
		nxt_st.perr = (st_ff.par_chk != st_ff.par2) && !st_ff.frame_prev;
		nxt_st.serr = fatal_err;
		// target side
		tgt_done = !st_ff.irdy2 && (st_ff.trdy || st_ff.stop);
		case (st_ff.ts)
		TS_IDLE: begin
			if (addr_phase && st_ff.idsel2
				&& (st_ff.cbe2 == CMD_IO_READ || st_ff.cbe2 == CMD_IO_WRITE)) begin
				nxt_st.ts = TS_SEL;
				nxt_st.devsel = 1'b1;
				nxt_st.topen = 1'b1;
				nxt_st.cfgw = (st_ff.cbe2 == CMD_IO_WRITE);
			end
		end
		TS_SEL: begin
			nxt_st.trdy = 1'b1;
			nxt_st.stop = tgt_stop_req;
			if (tgt_done) begin
				nxt_st.trdy = 1'b0;
				nxt_st.stop = st_ff.stop && !st_ff.frame2;
				nxt_st.ts = st_ff.frame2 ? TS_LAST : TS_SEL;
			end
		end
		TS_LAST: begin
			nxt_st.devsel = 1'b0;
			nxt_st.trdy = 1'b0;
			nxt_st.stop = 1'b0;
			nxt_st.ts = TS_IDLE;
		end
		default: nxt_st.ts = TS_IDLE;
		endcase
		nxt_st.cfg = (st_ff.ts == TS_SEL) && tgt_done;
		nxt_st.topen = (nxt_st.ts != TS_IDLE);
		// master side
		nxt_st.abort = 1'b0;
		case (st_ff.ms)
		MS_IDLE: begin
			nxt_st.req = 1'b0;
			if (mst_start) begin
				nxt_st.ms = MS_REQ;
				nxt_st.req = 1'b1;
			end
		end
		MS_REQ: begin
			if (!st_ff.gnt2 && st_ff.frame2 && st_ff.irdy2) begin
				nxt_st.ms = MS_ADDR;
				nxt_st.mframe = 1'b1;
				nxt_st.mact = 1'b1;
				nxt_st.req = 1'b0;
			end
		end
		MS_ADDR: begin
			nxt_st.ms = MS_WAIT;
			nxt_st.mirdy = 1'b1;
			nxt_st.mframe = 1'b0;
			nxt_st.tmo = TMO_ZERO;
		end
		MS_WAIT: begin
			nxt_st.tmo = st_ff.tmo + 3'h1;
			if (!st_ff.devsel2) begin
				nxt_st.ms = MS_DATA;
			end else if (st_ff.tmo == 3'(TMO_CYCLES - 1)) begin
				nxt_st.ms = MS_DONE;
				nxt_st.abort = 1'b1;
			end
		end
		MS_DATA: begin
			if ((!st_ff.trdy2 || !st_ff.stop2) && !st_ff.irdy2) begin
				nxt_st.ms = MS_DONE;
			end
		end
		MS_DONE: begin
			nxt_st.mirdy = 1'b0;
			nxt_st.mact = 1'b0;
			nxt_st.ms = MS_IDLE;
		end
		default: nxt_st.ms = MS_IDLE;
		endcase
		// sticky status; set wins over ack
		irq_set = '0;
		irq_set[IRQ_ABORT] = nxt_st.abort;
		irq_set[IRQ_PERR] = nxt_st.perr;
		irq_set[NUM_IRQ-1:2] = irq_ext;
		nxt_st.irq = (st_ff.irq & ~irq_ack) | irq_set;
		nxt_st.inta = |(nxt_st.irq & ~irq_mask);
	end

	// reset forces all strobes inactive, registers on rising edge
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			st_ff <= '0;
			st_ff.frame1 <= 1'b1;
			st_ff.frame2 <= 1'b1;
			st_ff.frame_prev <= 1'b1;
			st_ff.irdy1 <= 1'b1;
			st_ff.irdy2 <= 1'b1;
			st_ff.trdy1 <= 1'b1;
			st_ff.trdy2 <= 1'b1;
			st_ff.stop1 <= 1'b1;
			st_ff.stop2 <= 1'b1;
			st_ff.devsel1 <= 1'b1;
			st_ff.devsel2 <= 1'b1;
			st_ff.gnt1 <= 1'b1;
			st_ff.gnt2 <= 1'b1;
			st_ff.ms <= MS_IDLE;
			st_ff.ts <= TS_IDLE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// pin outputs, released during reset; driver enable high only in reset
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			frame_n_o <= 1'b1;
			frame_oe <= 1'b0;
			irdy_n_o <= 1'b1;
			irdy_oe <= 1'b0;
			trdy_n_o <= 1'b1;
			trdy_oe <= 1'b0;
			stop_n_o <= 1'b1;
			stop_oe <= 1'b0;
			devsel_n_o <= 1'b1;
			devsel_oe <= 1'b0;
			perr_n_o <= 1'b1;
			perr_oe <= 1'b0;
			serr_n_o <= 1'b1;
			serr_oe <= 1'b0;
			req_n_o <= 1'b1;
			req_oe <= 1'b0;
			inta_n_o <= 1'b1;
			inta_oe <= 1'b0;
			transmit_driver_enable <= 1'b1;
			mst_busy <= 1'b0;
			mst_abort <= 1'b0;
			cfg_access <= 1'b0;
			cfg_write <= 1'b0;
			irq_status <= '0;
		end else begin
			frame_n_o <= !nxt_st.mframe;
			frame_oe <= nxt_st.mact;
			irdy_n_o <= !nxt_st.mirdy;
			irdy_oe <= nxt_st.mact;
			trdy_n_o <= !nxt_st.trdy;
			trdy_oe <= nxt_st.topen;
			stop_n_o <= !nxt_st.stop;
			stop_oe <= nxt_st.topen;
			devsel_n_o <= !nxt_st.devsel;
			devsel_oe <= nxt_st.topen;
			perr_n_o <= !nxt_st.perr;
			perr_oe <= 1'b1;
			serr_n_o <= 1'b0; // open drain: only the enable moves
			serr_oe <= nxt_st.serr;
			req_n_o <= !nxt_st.req;
			req_oe <= 1'b1;
			inta_n_o <= 1'b0;
			inta_oe <= nxt_st.inta;
			transmit_driver_enable <= 1'b0;
			mst_busy <= (nxt_st.ms != MS_IDLE);
			mst_abort <= nxt_st.abort;
			cfg_access <= nxt_st.cfg;
			cfg_write <= nxt_st.cfg && nxt_st.cfgw;
			irq_status <= nxt_st.irq;
		end
	end

	chk_abort_raises_irq: assert property (@(posedge mclk) disable iff (!nrst)
		mst_abort |-> inta_oe || irq_mask[IRQ_ABORT]) else $error("abort without irq");
	chk_req_idle_low: assert property (@(posedge mclk) disable iff (!nrst)
		(st_ff.ms == MS_IDLE) && !mst_start |=> req_n_o) else $error("req while idle");
	chk_req_frame_free: assert property (@(posedge mclk) disable iff (!nrst)
		$rose(st_ff.mact) |-> $past(st_ff.frame2)) else $error("start over busy frame");
	chk_devsel_after_addr: assert property (@(posedge mclk) disable iff (!nrst)
		$rose(st_ff.devsel) |-> $past(st_ff.idsel2)) else $error("devsel without idsel");
	chk_perr_on_mismatch: assert property (@(posedge mclk) disable iff (!nrst)
		!perr_n_o |-> $past((st_ff.par_chk != st_ff.par2) && !st_ff.frame_prev))
		else $error("bad perr");
	chk_serr_follows: assert property (@(posedge mclk) disable iff (!nrst)
		fatal_err |=> serr_oe) else $error("serr missing");
	chk_inta_clear: assert property (@(posedge mclk) disable iff (!nrst)
		!(|(irq_status & ~$past(irq_mask))) |-> !inta_oe) else $error("inta stuck");
	chk_transmit_driver_enable_low: assert property (@(posedge mclk) disable iff (!nrst)
		$past(nrst) |-> !transmit_driver_enable) else $error("driver enable high");
	chk_abort_timeout: assert property (@(posedge mclk) disable iff (!nrst)
		((st_ff.ms == MS_WAIT) && st_ff.devsel2) [*6] |=> st_ff.ms == MS_DONE)
		else $error("no abort after timeout");
endmodule

/* File: rtl/psb_pkg.sv */
package psb_pkg;
	localparam logic [3:0] CMD_IO_READ = 4'h2;
	localparam logic [3:0] CMD_IO_WRITE = 4'h3;
	localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
	localparam logic [3:0] CMD_MEM_READ = 4'h6;
	localparam int DEVSEL_TIMEOUT = 6;
	localparam int NUM_IRQ = 4;
	localparam int IRQ_ABORT = 0;
	localparam int IRQ_PERR = 1;
	localparam logic [2:0] TMO_ZERO = 3'h0;
	typedef enum logic [2:0] {
		MS_IDLE = 3'b000,
		MS_REQ = 3'b001,
		MS_ADDR = 3'b011,
		MS_WAIT = 3'b010,
		MS_DATA = 3'b110,
		MS_DONE = 3'b111
	} psb_mst_t;
	typedef enum logic [1:0] {
		TS_IDLE = 2'b00,
		TS_SEL = 2'b01,
		TS_LAST = 2'b11
	} psb_tgt_t;
endpackage

/* File: verif/psb_bus_model.sv */
`timescale 1ns/10ps
module psb_bus_model (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// agent drive, resolved, pull-up when released, and the test's answer enable
	input wire logic req_n,
	input wire logic frame_n,
	input wire logic irdy_n,
	input wire logic answer,
	// arbiter and target answer
	output logic gnt_n,
	output logic devsel_n,
	output logic trdy_n
);
	logic [1:0] dly;
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			gnt_n <= 1'b1;
			devsel_n <= 1'b1;
			trdy_n <= 1'b1;
			dly <= 2'd0;
		end else begin
			gnt_n <= req_n;
			// count on after the one-cycle frame until the decode is done
			if (answer && dly != 2'h2 && (!frame_n || dly != 2'h0))
				dly <= dly + 2'h1;
			// slow decode, two cycles after the address
			if (dly == 2'h2) begin
				devsel_n <= 1'b0;
				trdy_n <= 1'b0;
			end
			// released lines fall back to the pull-up level
			if (frame_n && irdy_n && dly == 2'h2) begin
				dly <= 2'h0;
				devsel_n <= 1'b1;
				trdy_n <= 1'b1;
			end
		end
	end
endmodule

/* File: verif/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
	import psb_pkg::*;
	logic mclk = 0, nrst = 0, par = 0, frm_n = 1, rdy_n = 1, idsel = 0, answer = 0;
	logic mst_start = 0, tgt_stop_req = 0, fatal_err = 0;
	logic [31:0] ad = 0;
	logic [3:0] cbe = 0, irq_mask = 0, irq_ack = 0;
	logic [1:0] irq_ext = 0;
	logic frame_n_o, frame_oe, irdy_n_o, irdy_oe, trdy_n_o, trdy_oe, stop_n_o, stop_oe;
	logic devsel_n_o, devsel_oe, perr_n_o, perr_oe, serr_n_o, serr_oe, req_n_o, req_oe;
	logic inta_n_o, inta_oe, transmit_driver_enable, mst_busy, mst_abort, cfg_access, cfg_write;
	logic gnt_n, devsel_n, trdy_n;
	logic [3:0] irq_status;
	logic [1:0] exp_q[$];
	logic [3:0] cmds[3] = '{CMD_IO_READ, CMD_IO_WRITE, CMD_MEM_READ};
	int error_cnt = 0, comparisons = 0, seed = 71;
	wire m_req_n = req_oe ? req_n_o : 1'b1;
	wire m_frame_n = frame_oe ? frame_n_o : 1'b1;
	wire m_irdy_n = irdy_oe ? irdy_n_o : 1'b1;
	always #50 mclk = ~mclk;
	psb_agent u_dut (.mclk(mclk), .nrst(nrst), .ad_i(ad), .cbe_i(cbe), .par_i(par),
		.frame_n_i(m_frame_n & frm_n), .irdy_n_i(m_irdy_n & rdy_n), .trdy_n_i(trdy_n),
		.stop_n_i(1'b1), .devsel_n_i(devsel_n), .idsel_i(idsel), .gnt_n_i(gnt_n),
		.frame_n_o(frame_n_o), .frame_oe(frame_oe), .irdy_n_o(irdy_n_o), .irdy_oe(irdy_oe),
		.trdy_n_o(trdy_n_o), .trdy_oe(trdy_oe), .stop_n_o(stop_n_o), .stop_oe(stop_oe),
		.devsel_n_o(devsel_n_o), .devsel_oe(devsel_oe), .perr_n_o(perr_n_o), .perr_oe(perr_oe),
		.serr_n_o(serr_n_o), .serr_oe(serr_oe), .req_n_o(req_n_o), .req_oe(req_oe),
		.inta_n_o(inta_n_o), .inta_oe(inta_oe), .transmit_driver_enable(transmit_driver_enable),
		.mst_start(mst_start), .tgt_stop_req(tgt_stop_req), .fatal_err(fatal_err),
		.irq_mask(irq_mask), .irq_ack(irq_ack), .irq_ext(irq_ext), .mst_busy(mst_busy),
		.mst_abort(mst_abort), .cfg_access(cfg_access), .cfg_write(cfg_write),
		.irq_status(irq_status));
	psb_bus_model u_bus (.mclk(mclk), .nrst(nrst), .req_n(m_req_n), .frame_n(m_frame_n),
		.irdy_n(m_irdy_n), .answer(answer), .gnt_n(gnt_n), .devsel_n(devsel_n), .trdy_n(trdy_n));
	task automatic final_report();
		if (error_cnt == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	function automatic logic probe(input int sel);
		case (sel)
			0: return mst_busy === 1'b1;
			1: return mst_busy === 1'b0;
			2: return irq_status[0] === 1'b1;
			3: return inta_oe === 1'b0;
			4: return devsel_oe === 1'b1 && devsel_n_o === 1'b0;
			5: return trdy_oe === 1'b1 && (trdy_n_o === 1'b0 || stop_n_o === 1'b0);
			6: return perr_oe === 1'b1 && perr_n_o === 1'b0;
			7: return serr_oe === 1'b1 && serr_n_o === 1'b0;
			8: return irq_status[2] === 1'b1;
			default: return inta_oe === 1'b1 && inta_n_o === 1'b0;
		endcase
	endfunction
	// bounded wait, sampled on the falling edge where outputs are settled
	task automatic wait_for(input int sel);
		for (int i = 0; i < 60; i++) begin
			@(negedge mclk);
			if (probe(sel))
				return;
		end
		error_cnt++;
		$display("wrong value wait %0d expected 1 seen 0", sel);
		final_report();
	endtask
	// event monitor: pulse seen takes the oldest note off the queue
	always @(negedge mclk) begin
		if (nrst && (mst_abort === 1'b1 || cfg_access === 1'b1)) begin
			if (exp_q.size() == 0)
				chk("event", 32'h0000_0000, {cfg_access, mst_abort});
			else
				chk("event", exp_q.pop_front(), {cfg_access, mst_abort});
		end
	end
	initial begin
		repeat (3) @(negedge mclk);
		chk("tde reset", 32'h0000_0001, transmit_driver_enable);
		chk("oe reset", 32'h0000_0000, {frame_oe, devsel_oe, req_oe, serr_oe, inta_oe});
		@(posedge mclk) nrst <= 1'b1;
		repeat (2) @(posedge mclk);
		chk("tde run", 32'h0000_0000, transmit_driver_enable);
		// no target answers: abort, interrupt, mask, ack
		exp_q.push_back(2'b01);
		mst_start <= 1'b1;
		wait_for(0);
		@(posedge mclk) mst_start <= 1'b0;
		wait_for(2);
		wait_for(9);
		@(posedge mclk) irq_mask <= 4'h1;
		wait_for(3);
		@(posedge mclk) irq_mask <= 4'h0;
		wait_for(9);
		@(posedge mclk) irq_ack <= 4'h1;
		@(posedge mclk) irq_ack <= 4'h0;
		wait_for(3);
		chk("abort status", 32'h0000_0000, irq_status[0]);
		// answered transfer, start only after idle frame
		answer <= 1'b1;
		mst_start <= 1'b1;
		wait_for(0);
		@(posedge mclk) mst_start <= 1'b0;
		wait_for(1);
		chk("no abort", 32'h0000_0000, irq_status[0]);
		// config select with IO read, IO write and memory read commands
		foreach (cmds[k]) begin
			@(posedge mclk);
			ad <= $random(seed);
			cbe <= cmds[k];
			frm_n <= 1'b0;
			idsel <= 1'b1;
			tgt_stop_req <= (k == 1);
			@(posedge mclk);
			par <= ^{ad, cbe};
			frm_n <= 1'b1;
			rdy_n <= 1'b0;
			idsel <= 1'b0;
			cbe <= 4'h0;
			if (k < 2) begin
				exp_q.push_back(2'b10);
				wait_for(4);
				wait_for(5);
				if (k == 1)
					chk("stop", 32'h0000_0000, stop_n_o);
				@(negedge mclk);
				chk("cfg write", k, cfg_write);
			end else begin
				repeat (12) @(negedge mclk);
				chk("refused", 32'h0000_0000, devsel_oe);
			end
			@(posedge mclk) rdy_n <= 1'b1;
			tgt_stop_req <= 1'b0;
			repeat (4) @(posedge mclk);
		end
		// wrong parity one clock after the lines
		@(posedge mclk) ad <= $random(seed);
		cbe <= 4'h5;
		frm_n <= 1'b0;
		@(posedge mclk) par <= ~(^{ad, cbe});
		frm_n <= 1'b1;
		wait_for(6);
		@(posedge mclk) fatal_err <= 1'b1;
		wait_for(7);
		@(posedge mclk) fatal_err <= 1'b0;
		irq_ack <= 4'h2;
		irq_ext <= 2'b01;
		@(posedge mclk) irq_ext <= 2'b00;
		irq_ack <= 4'h0;
		wait_for(8);
		wait_for(9);
		chk("queue", 32'h0000_0000, exp_q.size());
		final_report();
	end
endmodule
